// [rtl/mcx_regs.sv]
// Purpose: auxiliary register bank of a host modem controller
// Assumes: classic wishbone slave, 32-bit words, byte addr = 4 * index
// Notes:   fifo core lives outside; it reports events and takes data
// Operation
// R1: overrun bit1, underrun bit0, cleared on read
// R2: ext bit3 and int bit2 clear on read
// R3: output latch low byte drives pins, resets zero
// R4: latch 7:4 gp, 3 mute, 2..0 relays
// R5: input register shows four pin levels
// R6: 3:2 gp, 1 line sense, 0 ring
// R7: timeout after (N+1)*256*depth erroring sample periods
// R8: timeout count write-only bits 11:8, reset zero
// R9: depth field bits 7:0, default 32
// R10: rx buffer full with enable raises interrupt
// R11: 12-bit error counter counts each error; underrun and overrun in one cycle count once
// R12: codec clock divided from crystal input
// R13: bits 7:6 select output stage
// R14: bits 5:3 ratio a, 2:0 ratio b
// R15: index 0 writes tx fifo, reads rx
// R16: reserved bits read zero, writes ignored
// R17: error counter saturates at maximum
//
// The Wishbone slave port was left to the implementer.
`default_nettype none
`include "mcx_cfg.svh"
module mcx_regs
  import mcx_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:2]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // fifo core side
  input  wire logic        tx_starve_i,
  input  wire logic        rx_overflow_i,
  input  wire logic        rx_full_i,
  input  wire logic        ext_irq_i,
  input  wire logic        ring_i,
  input  wire logic        sample_en_i,
  input  wire logic [15:0] rx_fifo_port_i,
  output logic      [15:0] tx_fifo_port_o,
  output logic             tx_push_o,
  output logic             rx_pop_o,
  output logic      [7:0]  buffer_depth_o,
  output logic             timeout_o,
  // pins
  input  wire logic [3:0]  pins_i,
  output logic      [7:0]  relay_o,
  input  wire logic        xtal_en_i,
  output logic             codec_clock_out_o,
  output logic             irq_o
);
  localparam int EW = `MCX_EVT_W;
  mcx_relay_t  relay_output_latch_q;
  mcx_pins_t   pin_s1_q;
  mcx_pins_t   pin_input_monitor_q;
  logic [3:0]  timeout_count_q;
  logic [7:0]  buffer_depth_q;
  logic [7:0]  codec_clock_divider_q;
  logic [11:0] buffer_error_counter_q;
  logic [EW-1:0] sts_q;
  logic [EW-1:0] irq_en_q;
  logic [EW-1:0] evt;
  logic        irq_enable_q;
  logic        ring_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [23:0] tout_cnt_q;
  logic [3:0]  tout_rep_q;
  logic        tout_q;
  logic        push_q;
  logic        pop_q;
  logic [15:0] txd_q;
  logic        clk_gen;
  logic        codec_q;
  logic        req;
  logic        wr;
  logic        rd;
  logic        any_err;
  logic [23:0] tout_lim;

  assign req = cyc_i && stb_i && !ack_q;
  assign wr  = req && we_i;
  assign rd  = req && !we_i;
  assign any_err = tx_starve_i || rx_overflow_i;

  // event vector; internal event is the enabled rx full request or the timeout pulse
  assign evt[`MCX_BIT_TX_STARVE] = tx_starve_i;  // R1
  assign evt[`MCX_BIT_RX_OVF]    = rx_overflow_i; // R1
  assign evt[`MCX_BIT_INT_IRQ]   = (rx_full_i && irq_enable_q) || tout_q; // R10
  assign evt[`MCX_BIT_EXT_IRQ]   = ext_irq_i;

  // one-cycle ack, registered one clock after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // sticky status per bit: set wins over read clear and clear register
  genvar g;
  generate
    for (g = 0; g < EW; g++)
    begin : g_sts
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          sts_q[g] <= 1'b0;
        else if (evt[g])
          sts_q[g] <= 1'b1;
        else if (rd && adr_i == `MCX_IDX_STATUS) // R1 R2
          sts_q[g] <= 1'b0;
        else if (wr && adr_i == `MCX_IDX_IRQ_CLR && sel_i[0] && dat_i[g])
          sts_q[g] <= 1'b0;
      end
    end
  endgenerate

  // ring status mirrors the synchronised ring pin, not sticky
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ring_q <= 1'b0;
    else
      ring_q <= ring_i;
  end

  // writable configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      relay_output_latch_q  <= `MCX_EXTOUT_RST; // R3
      timeout_count_q       <= `MCX_TOC_RST;    // R8
      buffer_depth_q        <= `MCX_DEPTH_RST;  // R9
      codec_clock_divider_q <= `MCX_CLKDIV_RST;
      irq_en_q              <= '0;
      irq_enable_q          <= 1'b0;
    end
    else if (wr)
    begin
      case (adr_i)
        `MCX_IDX_EXTIO: if (sel_i[0]) relay_output_latch_q <= dat_i[7:0]; // R3 R16
        `MCX_IDX_MISC:
        begin
          if (sel_i[0]) buffer_depth_q <= dat_i[7:0];   // R9
          if (sel_i[1]) timeout_count_q <= dat_i[11:8]; // R8
        end
        `MCX_IDX_CLKDIV: if (sel_i[0]) codec_clock_divider_q <= dat_i[7:0]; // R12
        `MCX_IDX_IRQ_EN: if (sel_i[0]) irq_en_q <= dat_i[EW-1:0];
        `MCX_IDX_CTRL:   if (sel_i[0]) irq_enable_q <= dat_i[0];
        default: ;
      endcase
    end
  end

  // input pins: two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_q            <= '0;
      pin_input_monitor_q <= '0;
    end
    else
    begin
      pin_s1_q            <= pins_i;
      pin_input_monitor_q <= pin_s1_q; // R5 R6
    end
  end

  // error counter saturates instead of wrapping
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      buffer_error_counter_q <= '0;
    else if (any_err && buffer_error_counter_q != `MCX_ERR_MAX) // R11 R17
      buffer_error_counter_q <= buffer_error_counter_q + 12'h1;
  end

  // timeout: depth*256 sample periods with errors, repeated N+1 times
  // a cleared flag restarts the count; a short error burst still times out while its sticky flag stays set
  assign tout_lim = {16'h0, buffer_depth_q} * {12'h0, `MCX_TOUT_UNIT}; // R7
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tout_cnt_q <= '0;
      tout_rep_q <= '0;
      tout_q     <= 1'b0;
    end
    else
    begin
      tout_q <= 1'b0;
      if (!(sts_q[`MCX_BIT_TX_STARVE] || sts_q[`MCX_BIT_RX_OVF] || any_err))
      begin
        tout_cnt_q <= '0;
        tout_rep_q <= '0;
      end
      else if (sample_en_i)
      begin
        if (tout_cnt_q + 24'h1 >= tout_lim && buffer_depth_q != 8'h0)
        begin
          tout_cnt_q <= '0;
          if (tout_rep_q == timeout_count_q) // R7
          begin
            tout_q     <= 1'b1;
            tout_rep_q <= '0;
          end
          else
            tout_rep_q <= tout_rep_q + 4'h1;
        end
        else
          tout_cnt_q <= tout_cnt_q + 24'h1;
      end
    end
  end

  // data port strobes toward the fifo core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      push_q <= 1'b0;
      pop_q  <= 1'b0;
      txd_q  <= '0;
    end
    else
    begin
      push_q <= wr && adr_i == `MCX_IDX_DATA; // R15
      pop_q  <= rd && adr_i == `MCX_IDX_DATA; // R15
      if (wr && adr_i == `MCX_IDX_DATA)
        txd_q <= dat_i[15:0];
    end
  end

  // read mux, reserved bits zero; write-only registers read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= '0;
    else if (rd)
    begin
      case (adr_i)
        `MCX_IDX_DATA:   rdat_q <= {16'h0, rx_fifo_port_i};
        `MCX_IDX_STATUS: rdat_q <= {23'h0, ring_q, 4'h0, sts_q}; // R16
        `MCX_IDX_EXTIO:  rdat_q <= {28'h0, pin_input_monitor_q}; // R5
        `MCX_IDX_MISC:   rdat_q <= {20'h0, buffer_error_counter_q}; // R11
        `MCX_IDX_IRQ_EN: rdat_q <= {28'h0, irq_en_q};
        `MCX_IDX_CTRL:   rdat_q <= {31'h0, irq_enable_q};
        default:         rdat_q <= '0;
      endcase
    end
  end

  // interrupt level from enabled sticky bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(sts_q & irq_en_q); // R10
  end

  mcx_clkgen u_clkgen (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .xtal_en_i (xtal_en_i),
    .div_i     (codec_clock_divider_q),
    .clk_o     (clk_gen)
  );

  // retime generated clock so the output is a flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      codec_q <= 1'b0;
    else
      codec_q <= clk_gen; // R12 R13 R14
  end

  // every output below is a plain rename of a flop
  assign codec_clock_out_o = codec_q;
  assign relay_o        = relay_output_latch_q; // R4
  assign ack_o          = ack_q;
  assign dat_o          = rdat_q;
  assign tx_fifo_port_o = txd_q;
  assign tx_push_o      = push_q;
  assign rx_pop_o       = pop_q;
  assign buffer_depth_o = buffer_depth_q;
  assign timeout_o      = tout_q;

  // checks
  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q) else $error("ack held too long"); // R15
  ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_overflow_i |=> sts_q[`MCX_BIT_RX_OVF]) else $error("overflow flag lost"); // R1
  clr_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && adr_i == `MCX_IDX_STATUS && evt == '0 |=> sts_q == '0)
    else $error("status not cleared"); // R2
  err_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    buffer_error_counter_q == `MCX_ERR_MAX |=> buffer_error_counter_q == `MCX_ERR_MAX)
    else $error("counter wrapped"); // R17
  err_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    any_err && buffer_error_counter_q != `MCX_ERR_MAX |=>
    buffer_error_counter_q == $past(buffer_error_counter_q) + 12'h1)
    else $error("counter missed error"); // R11
  pin_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 pin_input_monitor_q == $past(pins_i, 2)) else $error("pin sync wrong"); // R5
  rel_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == `MCX_IDX_EXTIO && sel_i[0] |=> relay_o == $past(dat_i[7:0]))
    else $error("latch not written"); // R3
  irq_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |(sts_q & irq_en_q) |=> irq_o) else $error("irq missing"); // R10
  push_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == `MCX_IDX_DATA |=> tx_push_o ##1 !tx_push_o)
    else $error("push not single"); // R15
  pop_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    rd && adr_i == `MCX_IDX_DATA |=> rx_pop_o ##1 !rx_pop_o)
    else $error("pop not single");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    evt[`MCX_BIT_EXT_IRQ] |=> sts_q[`MCX_BIT_EXT_IRQ])
    else $error("external flag lost to a clear");
  sts_rd_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    rd && adr_i == `MCX_IDX_STATUS |=> dat_o[EW-1:0] == $past(sts_q))
    else $error("status read not pre-clear value");
  tout_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    timeout_o |=> !timeout_o)
    else $error("timeout longer than one cycle");
  irq_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    !(|(sts_q & irq_en_q)) |=> !irq_o)
    else $error("irq without enabled flag");
  // covers for the main scenarios
  tout_cov: cover property (@(posedge clk_i) timeout_o);
  irq_cov: cover property (@(posedge clk_i) irq_o);
  sat_cov: cover property (@(posedge clk_i) buffer_error_counter_q == `MCX_ERR_MAX);
  rdclr_cov: cover property (@(posedge clk_i) rd && adr_i == `MCX_IDX_STATUS && sts_q != '0);
  pop_cov: cover property (@(posedge clk_i) rx_pop_o);
endmodule : mcx_regs
`default_nettype wire

// [rtl/mcx_cfg.svh]
// Purpose: named constants for the modem controller auxiliary registers
// Assumes: word-indexed registers on a 32-bit classic wishbone bus
// Notes:   byte address is four times the register index
`ifndef MCX_CFG_SVH
`define MCX_CFG_SVH
`define MCX_IDX_DATA      4'h0
`define MCX_IDX_STATUS    4'h1
`define MCX_IDX_EXTIO     4'h2
`define MCX_IDX_MISC      4'h3
`define MCX_IDX_CLKDIV    4'h5
`define MCX_IDX_IRQ_EN    4'h6
`define MCX_IDX_IRQ_CLR   4'h7
`define MCX_IDX_CTRL      4'h8
`define MCX_BIT_TX_STARVE 0
`define MCX_BIT_RX_OVF    1
`define MCX_BIT_INT_IRQ   2
`define MCX_BIT_EXT_IRQ   3
`define MCX_BIT_RING      8
`define MCX_EXTOUT_RST    8'h00
`define MCX_TOC_RST       4'h0
`define MCX_DEPTH_RST     8'h20
`define MCX_CLKDIV_RST    8'h80
`define MCX_TOUT_UNIT     12'h100
`define MCX_ERR_MAX       12'hFFF
`define MCX_EVT_W         4
`endif

// [rtl/mcx_pkg.sv]
// Purpose: shared types for the modem controller auxiliary registers
// Assumes: mcx_cfg.svh holds all numeric constants
// Notes:   types only
`default_nettype none
package mcx_pkg;
  // output latch fields in pin order
  typedef struct packed {
    logic [3:0] gp_out;
    logic       spk_mute;
    logic       handset_relay;
    logic       cid_relay;
    logic       offhook_relay;
  } mcx_relay_t;
  // input pin levels
  typedef struct packed {
    logic [1:0] gp_in;
    logic       line_current_sense;
    logic       ring_detect;
  } mcx_pins_t;
  // output stage select
  typedef enum logic [1:0] {
    MCX_X2_INV = 2'b00,
    MCX_X2     = 2'b01,
    MCX_DIV1   = 2'b10,
    MCX_DIV2   = 2'b11
  } mcx_stage_t;
endpackage : mcx_pkg
`default_nettype wire

// [rtl/mcx_clkgen.sv]
// Purpose: codec clock generator from the crystal clock enable
// Assumes: xtal_en_i is one-cycle pulse per crystal edge (half period)
// Notes:   ratio b in half-steps; x2 of an undivided clock cannot pass the half-edge rate
`default_nettype none
`include "mcx_cfg.svh"
module mcx_clkgen
  import mcx_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       xtal_en_i,
  input  wire logic [7:0] div_i,
  // output
  output logic            clk_o
);
  logic [6:0] cnt_q;
  logic [6:0] half_lim;
  logic [6:0] mid;
  logic       x2_tick;
  logic       pre_q;
  logic       stage_q;
  logic [3:0] ra;
  logic [3:0] rb2;
  logic [7:0] tot;
  // ratio a and twice ratio b; the reserved a code falls back to 1
  always_comb
  begin
    ra = (div_i[5:3] == 3'b110) ? 4'h1 :
         (div_i[5:3] == 3'b111) ? 4'h8 : {1'b0, div_i[5:3]} + 4'h1; // R14
    rb2 = (div_i[2:0] == 3'b000) ? 4'h2 : {1'b0, div_i[2:0]} + 4'h4; // R14
    tot = ra * rb2;
    // each phase lasts half of tot; an odd total lengthens the high phase by one
    half_lim = tot[7:1] + {6'h0, tot[0] & pre_q} - 7'h1;
    mid = (half_lim + 7'h1) >> 1;
    x2_tick = xtal_en_i && (cnt_q == 7'h0 || cnt_q == mid);
  end
  // divider in xtal half periods: a*b*2 half edges per pre-clock period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 7'h0;
      pre_q <= 1'b0;
    end
    else if (xtal_en_i)
    begin
      if (cnt_q >= half_lim)
      begin
        cnt_q <= 7'h0;
        pre_q <= ~pre_q;
      end
      else
        cnt_q <= cnt_q + 7'h1;
    end
  end
  // output stage; x2 approximated by toggling twice as often
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stage_q <= 1'b0;
    else
    begin
      case (mcx_stage_t'(div_i[7:6]))
        MCX_X2_INV: if (x2_tick) stage_q <= ~stage_q; // R13
        MCX_X2:     if (x2_tick) stage_q <= ~stage_q; // R13
        MCX_DIV1:   stage_q <= pre_q;
        MCX_DIV2:   if (xtal_en_i && cnt_q == 7'h0 && pre_q) stage_q <= ~stage_q;
        default:    stage_q <= pre_q;
      endcase
    end
  end
  // inverted x2 shares the toggle and flips only the output
  assign clk_o = (mcx_stage_t'(div_i[7:6]) == MCX_X2_INV) ? ~stage_q : stage_q; // R13
endmodule : mcx_clkgen
`default_nettype wire

// [bench/mcx_host_model.sv]
// Purpose: crystal and sample-rate source standing beside the register bank
// Assumes: one clock domain; a crystal half period every third clk_i cycle
// Notes:   counts codec clock edges so the bench can compare divider modes
`default_nettype none
module mcx_host_model
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // crystal side
  input  wire logic        codec_clk_i,
  output logic             xtal_en_o,
  output logic             sample_en_o,
  output logic      [15:0] edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q;
  logic       last_q;
  // slow crystal so that every divider ratio stays visible in edge counts
  always_ff @(posedge clk_i)
  begin
    ph_q    <= (rst_i || ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    last_q  <= codec_clk_i;
    edges_o <= rst_i ? 16'h0 : edges_o + 16'(codec_clk_i != last_q);
  end
  // one sample period per clock keeps the long time-out short
  assign xtal_en_o   = (ph_q == 2'h2);
  assign sample_en_o = !rst_i;
endmodule : mcx_host_model
`default_nettype wire

// [bench/modem_controller_aux_registers_tb_top.sv]
// Purpose: self-checking bench for the auxiliary register bank
// Assumes: classic wishbone single cycles, 16-bit registers in the low half
// Notes:   each scenario is its own task and judges its own results
`default_nettype none
module modem_controller_aux_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, ack, starve, ovf, full, ext, ring;
  logic        push, pop, tout, xen, sen, cclk, irq;
  logic [3:0]  adr, sel, pins;
  logic [31:0] wdat, rdat, r;
  logic [15:0] rxd, txd, edges;
  logic [7:0]  depth, relay;
  int          mismatches, n_checks, cycles;

  mcx_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .tx_starve_i(starve), .rx_overflow_i(ovf), .rx_full_i(full), .ext_irq_i(ext),
    .ring_i(ring), .sample_en_i(sen), .rx_fifo_port_i(rxd), .tx_fifo_port_o(txd),
    .tx_push_o(push), .rx_pop_o(pop), .buffer_depth_o(depth), .timeout_o(tout),
    .pins_i(pins), .relay_o(relay), .xtal_en_i(xen), .codec_clock_out_o(cclk),
    .irq_o(irq));
  mcx_host_model host (.clk_i(clk_i), .rst_i(rst_i), .codec_clk_i(cclk),
    .xtal_en_o(xen), .sample_en_o(sen), .edges_o(edges));

  // 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h3;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1);
    r = rdat;
    chk(32'(n), 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rdc

  task automatic t_reset();
    chk({24'h0, relay}, 32'h0);
    chk({24'h0, depth}, 32'h20);
    rdc(4'h1, 32'h0);
    rdc(4'h3, 32'h0);
    rdc(4'h4, 32'h0);
    rdc(4'h5, 32'h0);
    $display("reset test done");
  endtask : t_reset

  // starve and ext together, overflow a cycle later: two counted errors
  task automatic t_flags();
    @(posedge clk_i);
    starve <= 1'b1;
    ext    <= 1'b1;
    @(posedge clk_i);
    starve <= 1'b0;
    ext    <= 1'b0;
    ovf    <= 1'b1;
    @(posedge clk_i);
    ovf    <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdc(4'h1, 32'hB);
    rdc(4'h1, 32'h0);
    rdc(4'h3, 32'h2);
    $display("flag test done");
  endtask : t_flags

  task automatic t_latch();
    wb(1'b1, 4'h2, 32'hFFFF_FFA5);
    chk({24'h0, relay}, 32'hA5);
    pins <= 4'hA;
    repeat (4) @(posedge clk_i);
    rdc(4'h2, 32'hA);
    pins <= 4'h5;
    repeat (4) @(posedge clk_i);
    rdc(4'h2, 32'h5);
    $display("latch test done");
  endtask : t_latch

  // depth 16 and count 1: time-out after 2*16*256 erroring sample periods
  task automatic t_timeout();
    int n;
    wb(1'b1, 4'h3, 32'h0000_F110);
    chk({24'h0, depth}, 32'h10);
    @(posedge clk_i);
    starve <= 1'b1;
    @(posedge clk_i);
    starve <= 1'b0;
    n = 0;
    while (tout !== 1'b1 && n < 10000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 8186 && n <= 8198), 32'h1);
    rdc(4'h1, 32'h5);
    rdc(4'h3, 32'h3);
    $display("timeout test done");
  endtask : t_timeout

  task automatic t_irq();
    wb(1'b1, 4'h8, 32'h1);
    wb(1'b1, 4'h6, 32'h4);
    full <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 4'h6, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 4'h6, 32'h4);
    full <= 1'b0;
    wb(1'b1, 4'h7, 32'h4);
    ring <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rdc(4'h1, 32'h100);
    ring <= 1'b0;
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_data();
    rxd <= 16'hBEEF;
    wb(1'b1, 4'h0, 32'h0000_1234);
    chk({31'h0, push}, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({16'h0, txd}, 32'h1234);
    rdc(4'h0, 32'hBEEF);
    chk({31'h0, pop}, 32'h1);
    $display("data port test done");
  endtask : t_data

  task automatic meas(input logic [7:0] d, output int e);
    int e0;
    wb(1'b1, 4'h5, {24'h0, d});
    repeat (12) @(posedge clk_i);
    e0 = edges;
    repeat (600) @(posedge clk_i);
    e = int'(edges) - e0;
  endtask : meas

  // /2 stage and ratio a of 2 each halve the undivided edge rate
  task automatic t_clock();
    int e1, e2, ea, ex, ei;
    meas(8'h80, e1);
    meas(8'hC0, e2);
    meas(8'h88, ea);
    meas(8'h48, ex);
    meas(8'h08, ei);
    chk(32'(e1 > 0), 32'h1);
    chk(32'(e1 >= 2 * e2 - 4 && e1 <= 2 * e2 + 4), 32'h1);
    chk(32'(e1 >= 2 * ea - 4 && e1 <= 2 * ea + 4), 32'h1);
    chk(32'(ex >= 2 * ea - 4 && ex <= 2 * ea + 4), 32'h1);
    chk(32'(ei >= ex - 4 && ei <= ex + 4), 32'h1);
    $display("clock test done");
  endtask : t_clock

  // main sequence
  initial
  begin
    {cyc, stb, we, starve, ovf, full, ext, ring} = 8'h0;
    adr  = 4'h0;
    sel  = 4'h0;
    pins = 4'h0;
    wdat = 32'h0;
    rxd  = 16'h0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_flags();
    t_latch();
    t_timeout();
    t_irq();
    t_data();
    t_clock();
    end_sim();
  end
endmodule : modem_controller_aux_registers_tb_top
`default_nettype wire
